// >>> sps_pkg.sv
package sps_pkg;
    // register byte offsets
    localparam logic [11:0] SPS_CTRL_OFS   = 12'h000;
    localparam logic [11:0] SPS_D1LOW_OFS  = 12'h004;
    localparam logic [11:0] SPS_D2HOLD_OFS = 12'h008;
    localparam logic [11:0] SPS_D2LOW_OFS  = 12'h00C;
    localparam logic [11:0] SPS_CSET_OFS   = 12'h010;
    localparam logic [11:0] SPS_USET_OFS   = 12'h014;
    localparam logic [11:0] SPS_RETX_OFS   = 12'h018;
    localparam logic [11:0] SPS_STAT_OFS   = 12'h01C;
    // control field positions
    localparam int SPS_CTRL_D1PD  = 0;
    localparam int SPS_CTRL_D2PD  = 1;
    localparam int SPS_CTRL_REQ   = 2;
    localparam int SPS_CTRL_STOP  = 3;
    localparam int SPS_CTRL_DDRON = 4;
    // timing
    localparam int SPS_CLK_KHZ    = 25000;
    localparam int SPS_D1LOW_US   = 3000;
    localparam int SPS_D2HOLD_US  = 1000;
    localparam int SPS_D2LOW_US   = 2000;
    localparam int SPS_SETTLE_US  = 10;
    localparam int SPS_RETX_US    = 187;
    localparam logic [31:0] SPS_D1LOW_RST  = 32'(SPS_D1LOW_US * SPS_CLK_KHZ / 1000);
    localparam logic [31:0] SPS_D2HOLD_RST = 32'(SPS_D2HOLD_US * SPS_CLK_KHZ / 1000);
    localparam logic [31:0] SPS_D2LOW_RST  = 32'(SPS_D2LOW_US * SPS_CLK_KHZ / 1000);
    localparam logic [31:0] SPS_SET_RST    = 32'(SPS_SETTLE_US * SPS_CLK_KHZ / 1000);
    localparam logic [31:0] SPS_RETX_RST   = 32'(SPS_RETX_US * SPS_CLK_KHZ / 1000);
    // sequencer states
    typedef enum logic [3:0] {
        SPS_RUN     = 4'h0,
        SPS_HOLD    = 4'h1,
        SPS_LOWWAIT = 4'h2,
        SPS_OFF     = 4'h3,
        SPS_CUP     = 4'h4,
        SPS_CSET    = 4'h5,
        SPS_UUP     = 4'h6,
        SPS_USET    = 4'h7,
        SPS_STOPOFF = 4'h8
    } sps_state_t;
    // outputs toward the regulator ic
    typedef struct packed {
        logic core_domain_power_request;
        logic cpu_domain_power_request;
        logic delayed_cpu_reset_out;
    } sps_pwr_t;
endpackage

// >>> sps_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per bit
module sps_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff; // first stage, read only by q
    // sample then resample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // sps_sync
`default_nettype wire

// >>> sps_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter, one-cycle done pulse when it reaches one
module sps_timer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        start,
    input  wire logic [31:0] load,
    output logic             busy,
    output logic             done
);
    logic [31:0] cnt_ff;
    // a zero load still costs one cycle so done is always seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 32'h0000_0000;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_ff <= load;
                busy   <= 1'b1;
            end else if (busy) begin
                if (cnt_ff <= 32'h0000_0001) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 32'h0000_0001;
                end
            end
        end
    end
endmodule // sps_timer
`default_nettype wire

// >>> sps_seq.sv
`timescale 1ns/1ps
`default_nettype none
// standby power sequencer: drives core and cpu power requests and delayed
// cpu reset to the regulator ic, with programmable timers over apb
module sps_seq
    import sps_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // wake sources and supply monitors (async pins)
    input  wire logic        wake_pin,
    input  wire logic        extended_interrupt_line_two,
    input  wire logic        wake_other,
    input  wire logic        core_supply_ready_threshold,
    input  wire logic        cpu_supply_ready_threshold,
    // system handshake
    input  wire logic        cpus_off,
    // regulator ic control inputs
    output logic             regulator_ctrl_input_one,
    output logic             regulator_ctrl_input_two,
    output logic             regulator_ctrl_input_three,
    // clock and cpu1 control
    output logic             clocks_enable,
    output logic             cpu1_reset_n,
    output logic             full_run_state
);
    // synchronised pins
    logic [5:0] pin_s;
    sps_sync #(.W(6)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({wake_pin, extended_interrupt_line_two, wake_other,
                   core_supply_ready_threshold, cpu_supply_ready_threshold, cpus_off}),
        .q       (pin_s)
    );
    wire fast_wake  = pin_s[5] | pin_s[4];   // pin or line two
    wire any_wake   = fast_wake | pin_s[3];
    wire core_rdy   = pin_s[2];
    wire cpu_rdy    = pin_s[1];
    wire cpus_gone  = pin_s[0];

    // registers
    logic [4:0]  ctrl_ff;
    logic [31:0] d1low_ff, d2hold_ff, d2low_ff, cset_ff, uset_ff, retx_ff;
    sps_state_t  st_ff, nxt_st;
    logic        wake_pend_ff, nxt_wake_pend;  // latched early wake
    logic        from_stop_ff;                 // wake path was low-voltage stop
    sps_pwr_t    pwr_ff, nxt_pwr;

    // apb decode, single-cycle answer
    wire acc   = psel & penable;
    wire wr    = acc & pwrite;
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction
    wire mapped = hit(paddr, SPS_CTRL_OFS) | hit(paddr, SPS_D1LOW_OFS) |
                  hit(paddr, SPS_D2HOLD_OFS) | hit(paddr, SPS_D2LOW_OFS) |
                  hit(paddr, SPS_CSET_OFS) | hit(paddr, SPS_USET_OFS) |
                  hit(paddr, SPS_RETX_OFS) | hit(paddr, SPS_STAT_OFS);
    wire [31:0] stat_word = {22'h00_0000, wake_pend_ff, from_stop_ff, pwr_ff, st_ff, 1'b0};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            SPS_CTRL_OFS:   rd_mux = {27'h000_0000, ctrl_ff};
            SPS_D1LOW_OFS:  rd_mux = d1low_ff;
            SPS_D2HOLD_OFS: rd_mux = d2hold_ff;
            SPS_D2LOW_OFS:  rd_mux = d2low_ff;
            SPS_CSET_OFS:   rd_mux = cset_ff;
            SPS_USET_OFS:   rd_mux = uset_ff;
            SPS_RETX_OFS:   rd_mux = retx_ff;
            SPS_STAT_OFS:   rd_mux = stat_word;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // timers: d1 min-low, d2 hold-off, d2 min-low, settle (shared)
    logic t1_start, t2_start, t3_start, ts_start;
    logic t1_busy, t2_busy, t3_busy, ts_busy;
    logic t1_done, t2_done, t3_done, ts_done;
    logic [31:0] ts_load;
    sps_timer u_d1low (.pclk(pclk), .presetn(presetn), .start(t1_start),
                       .load(d1low_ff), .busy(t1_busy), .done(t1_done));
    sps_timer u_d2hold (.pclk(pclk), .presetn(presetn), .start(t2_start),
                        .load(d2hold_ff), .busy(t2_busy), .done(t2_done));
    sps_timer u_d2low (.pclk(pclk), .presetn(presetn), .start(t3_start),
                       .load(d2low_ff), .busy(t3_busy), .done(t3_done));
    sps_timer u_settle (.pclk(pclk), .presetn(presetn), .start(ts_start),
                        .load(ts_load), .busy(ts_busy), .done(ts_done));
    wire unused_done = t1_done | t3_done;

    wire lows_busy  = t1_busy | t3_busy;
    wire req_ctrl   = ctrl_ff[SPS_CTRL_REQ];
    wire pd_ok      = ctrl_ff[SPS_CTRL_D1PD] & ctrl_ff[SPS_CTRL_D2PD];
    wire wake_seen  = any_wake | wake_pend_ff;

    // sequencer next state
    always_comb begin
        nxt_st        = st_ff;
        nxt_pwr       = pwr_ff;
        nxt_wake_pend = wake_pend_ff | (any_wake & lows_busy);
        t1_start      = 1'b0;
        t2_start      = 1'b0;
        t3_start      = 1'b0;
        ts_start      = 1'b0;
        ts_load       = cset_ff;
        case (st_ff)
            SPS_RUN: begin
                nxt_wake_pend = 1'b0;
                if (req_ctrl && pd_ok && cpus_gone) begin
                    nxt_pwr.cpu_domain_power_request = 1'b0;
                    nxt_pwr.delayed_cpu_reset_out    = 1'b0;
                    t1_start = 1'b1;
                    if (ctrl_ff[SPS_CTRL_STOP]) begin
                        nxt_pwr.core_domain_power_request = 1'b0;
                        nxt_st = SPS_STOPOFF;
                    end else begin
                        t2_start = 1'b1;
                        nxt_st   = SPS_HOLD;
                    end
                end
            end
            SPS_HOLD: begin
                if (t2_done) begin
                    nxt_pwr.core_domain_power_request = 1'b0;
                    t3_start = 1'b1;
                    nxt_st   = SPS_LOWWAIT;
                end
            end
            SPS_LOWWAIT, SPS_OFF: begin
                // wake held off until both min-low timers end
                if (!lows_busy && wake_seen) begin
                    nxt_pwr.core_domain_power_request = 1'b1;
                    nxt_wake_pend = 1'b0;
                    nxt_st = SPS_CUP;
                end else if (!lows_busy) begin
                    nxt_st = SPS_OFF;
                end
            end
            SPS_STOPOFF: begin
                if (!lows_busy && wake_seen) begin
                    nxt_wake_pend = 1'b0;
                    nxt_pwr.core_domain_power_request = 1'b1;
                    if (fast_wake) begin
                        // both requests together, retention time applied later as the minimum cpu settle
                        nxt_pwr.cpu_domain_power_request = 1'b1;
                        nxt_pwr.delayed_cpu_reset_out    = 1'b1;
                        nxt_st = SPS_UUP;
                    end else begin
                        ts_start = 1'b1;
                        ts_load  = retx_ff;
                        nxt_st   = SPS_CSET;
                    end
                end
            end
            SPS_CUP: begin
                if (core_rdy) begin
                    ts_start = 1'b1;
                    nxt_st   = SPS_CSET;
                end
            end
            SPS_CSET: begin
                if (ts_done) begin
                    nxt_pwr.cpu_domain_power_request = 1'b1;
                    nxt_pwr.delayed_cpu_reset_out    = 1'b1;
                    nxt_st = SPS_UUP;
                end
            end
            SPS_UUP: begin
                if (cpu_rdy) begin
                    ts_start = 1'b1;
                    ts_load  = (from_stop_ff && uset_ff < retx_ff) ? retx_ff : uset_ff;
                    nxt_st   = SPS_USET;
                end
            end
            SPS_USET: begin
                if (ts_done) begin
                    nxt_st = SPS_RUN;
                end
            end
            default: nxt_st = SPS_RUN;
        endcase
    end

    // state, wake latch and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff        <= SPS_RUN;
            pwr_ff       <= 3'b111;
            wake_pend_ff <= 1'b0;
            from_stop_ff <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            pwr_ff       <= nxt_pwr;
            wake_pend_ff <= nxt_wake_pend;
            if (st_ff == SPS_RUN && nxt_st != SPS_RUN) begin
                from_stop_ff <= (nxt_st == SPS_STOPOFF);
            end
        end
    end

    // pins and cpu control from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_ctrl_input_one   <= 1'b1;
            regulator_ctrl_input_two   <= 1'b1;
            regulator_ctrl_input_three <= 1'b1;
            clocks_enable              <= 1'b1;
            cpu1_reset_n               <= 1'b1;
            full_run_state             <= 1'b1;
        end else begin
            regulator_ctrl_input_one   <= nxt_pwr.core_domain_power_request;
            regulator_ctrl_input_two   <= nxt_pwr.cpu_domain_power_request;
            regulator_ctrl_input_three <= nxt_pwr.delayed_cpu_reset_out;
            clocks_enable              <= nxt_pwr.cpu_domain_power_request;
            // cpu1 held in reset until it reboots from boot rom
            cpu1_reset_n               <= (nxt_st == SPS_RUN);
            full_run_state             <= (nxt_st == SPS_RUN);
        end
    end

    // register writes; request bit self-clears once entry starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff   <= 5'h00;
            d1low_ff  <= SPS_D1LOW_RST;
            d2hold_ff <= SPS_D2HOLD_RST;
            d2low_ff  <= SPS_D2LOW_RST;
            cset_ff   <= SPS_SET_RST;
            uset_ff   <= SPS_SET_RST;
            retx_ff   <= SPS_RETX_RST;
        end else begin
            if (wr && hit(paddr, SPS_CTRL_OFS))   ctrl_ff   <= pwdata[4:0];
            else if (st_ff == SPS_RUN && nxt_st != SPS_RUN)
                ctrl_ff[SPS_CTRL_REQ] <= 1'b0;
            if (wr && hit(paddr, SPS_D1LOW_OFS))  d1low_ff  <= pwdata;
            if (wr && hit(paddr, SPS_D2HOLD_OFS)) d2hold_ff <= pwdata;
            if (wr && hit(paddr, SPS_D2LOW_OFS))  d2low_ff  <= pwdata;
            if (wr && hit(paddr, SPS_CSET_OFS))   cset_ff   <= pwdata;
            if (wr && hit(paddr, SPS_USET_OFS))   uset_ff   <= pwdata;
            if (wr && hit(paddr, SPS_RETX_OFS))   retx_ff   <= pwdata;
        end
    end

    // apb answer: registered, one wait state-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // checks: request lines, run and cpu1 outputs and the wake latch against state and timers

    // reset line is a copy of the cpu request
    a_reset_follows_cpu: assert property (@(posedge pclk) disable iff (!presetn)
        regulator_ctrl_input_three == regulator_ctrl_input_two)
        else $error("delayed reset differs from cpu request");

    // steps of the three transitions
    sequence s_std_entry;
        st_ff == SPS_RUN && nxt_st == SPS_HOLD;
    endsequence
    sequence s_std_wake;
        (st_ff == SPS_LOWWAIT || st_ff == SPS_OFF) && nxt_st == SPS_CUP;
    endsequence
    sequence s_fast_wake;
        st_ff == SPS_STOPOFF && nxt_st == SPS_UUP;
    endsequence

    // standby entry touches the cpu side only
    a_entry_cpu_only: assert property (@(posedge pclk) disable iff (!presetn)
        s_std_entry |=> !regulator_ctrl_input_two && regulator_ctrl_input_one)
        else $error("standby entry did not drop the cpu request alone");

    // core request survives the cpu drop
    a_cpu_first_drop: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(regulator_ctrl_input_two) && st_ff == SPS_HOLD |-> regulator_ctrl_input_one)
        else $error("core request dropped with cpu request");

    // cpu rail must be gone before the core rail
    a_hold_core_high: assert property (@(posedge pclk) disable iff (!presetn)
        t2_busy |-> regulator_ctrl_input_one)
        else $error("core request fell during hold-off");

    // hold-off end drops the core request
    a_hold_expiry_drop: assert property (@(posedge pclk) disable iff (!presetn)
        t2_done && st_ff == SPS_HOLD |=> !regulator_ctrl_input_one)
        else $error("core request not dropped after hold-off");

    // core rail gets its full discharge time
    a_core_min_low: assert property (@(posedge pclk) disable iff (!presetn)
        t3_busy |-> !regulator_ctrl_input_one)
        else $error("core request rose during min-low");

    // cpu rail gets its full discharge time
    a_cpu_min_low: assert property (@(posedge pclk) disable iff (!presetn)
        t1_busy |-> !regulator_ctrl_input_two)
        else $error("cpu request rose during min-low");

    // standby wake brings the core up alone
    a_core_before_cpu: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(regulator_ctrl_input_one) && !from_stop_ff |-> !regulator_ctrl_input_two)
        else $error("cpu request rose with core on standby wake");

    // same, seen from the state change
    a_wake_core_first: assert property (@(posedge pclk) disable iff (!presetn)
        s_std_wake |=> regulator_ctrl_input_one && !regulator_ctrl_input_two)
        else $error("standby wake did not raise the core request alone");

    // no cpu request while the core rail ramps
    a_core_rdy_gate: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == SPS_CUP |=> !regulator_ctrl_input_two && !clocks_enable)
        else $error("cpu request before core ready");

    // cpu request and clocks follow the core settle
    a_settle_then_cpu: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == SPS_CSET && ts_done |=> regulator_ctrl_input_two && clocks_enable)
        else $error("cpu request late after core settle");

    // run and cpu1 release after the cpu settle
    a_run_after_settle: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff == SPS_USET && ts_done |=> full_run_state && cpu1_reset_n)
        else $error("run state not entered after cpu settle");

    // pin or line two wake raises both requests
    a_fast_wake_both: assert property (@(posedge pclk) disable iff (!presetn)
        s_fast_wake |=> regulator_ctrl_input_one && regulator_ctrl_input_two)
        else $error("fast stop wake did not raise both requests");

    // a wake during a min-low timer is kept
    a_wake_kept: assert property (@(posedge pclk) disable iff (!presetn)
        any_wake && lows_busy |=> wake_pend_ff)
        else $error("early wake dropped");
endmodule // sps_seq
`default_nettype wire

// >>> sps_reg_model.sv
`timescale 1ns/1ps
`default_nettype none
// regulator ic stand-in: supply-ready levels follow the control inputs late
module sps_reg_model #(
    parameter int PDLY = 20  // internal switch delay in cycles, shortened
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // slow mode stretches the cpu rail ramp threefold
    input  wire logic slow,
    // control inputs from the sequencer
    input  wire logic regulator_ctrl_input_one,
    input  wire logic regulator_ctrl_input_two,
    input  wire logic regulator_ctrl_input_three,
    // supply monitors back to the sequencer
    output logic      core_supply_ready_threshold,
    output logic      cpu_supply_ready_threshold
);
    int   core_cnt_ff;  // cycles the core level has disagreed
    int   cpu_cnt_ff;   // cycles the cpu level has disagreed
    logic core_ff;      // core rail state
    logic cpu_ff;       // cpu rail state
    wire  cpu_want = regulator_ctrl_input_two & regulator_ctrl_input_three;
    wire  [31:0] cpu_dly = slow ? 32'(3 * PDLY) : 32'(PDLY);

    // core rail switches only after the level held for the full delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_cnt_ff <= 0;
            core_ff     <= 1'b1;
        end else if (regulator_ctrl_input_one == core_ff) begin
            core_cnt_ff <= 0;
        end else if (core_cnt_ff >= PDLY - 1) begin
            core_ff     <= regulator_ctrl_input_one;
            core_cnt_ff <= 0;
        end else begin
            core_cnt_ff <= core_cnt_ff + 1;
        end
    end

    // cpu rail, same scheme, optional slow ramp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_cnt_ff <= 0;
            cpu_ff     <= 1'b1;
        end else if (cpu_want == cpu_ff) begin
            cpu_cnt_ff <= 0;
        end else if (32'(cpu_cnt_ff) >= cpu_dly - 1) begin
            cpu_ff     <= cpu_want;
            cpu_cnt_ff <= 0;
        end else begin
            cpu_cnt_ff <= cpu_cnt_ff + 1;
        end
    end

    // dram and always-on rails are not modelled, they never switch
    assign core_supply_ready_threshold = core_ff;
    assign cpu_supply_ready_threshold  = cpu_ff;
endmodule // sps_reg_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
// standby sequencer bench: apb setup, standby round trip, three stop wakes
module testbench;
    import sps_pkg::*;
    localparam int PDLY = 20;
    logic pclk, presetn, psel, penable, pwrite, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, hold, d2low;
    logic pready, pslverr, wake_pin, extended_interrupt_line_two, wake_other;
    logic core_supply_ready_threshold, cpu_supply_ready_threshold, cpus_off;
    logic regulator_ctrl_input_one, regulator_ctrl_input_two, regulator_ctrl_input_three;
    logic clocks_enable, cpu1_reset_n, full_run_state;
    logic [2:0]  prev;
    logic [2:0]  sq[$];  // expected regulator levels, in order
    logic [33:0] aq[$];  // expected apb answers {is_read, slverr, data}
    int n_fail, checked, seed, n, k;
    wire [2:0] trip = {regulator_ctrl_input_one, regulator_ctrl_input_two,
                       regulator_ctrl_input_three};
    wire [5:0] obs  = {trip, clocks_enable, cpu1_reset_n, full_run_state};

    sps_seq sps_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_pin(wake_pin), .wake_other(wake_other),
        .extended_interrupt_line_two(extended_interrupt_line_two),
        .core_supply_ready_threshold(core_supply_ready_threshold),
        .cpu_supply_ready_threshold(cpu_supply_ready_threshold), .cpus_off(cpus_off),
        .regulator_ctrl_input_one(regulator_ctrl_input_one),
        .regulator_ctrl_input_two(regulator_ctrl_input_two),
        .regulator_ctrl_input_three(regulator_ctrl_input_three),
        .clocks_enable(clocks_enable), .cpu1_reset_n(cpu1_reset_n),
        .full_run_state(full_run_state));
    sps_reg_model #(.PDLY(PDLY)) sps_reg_model_i (.pclk(pclk), .presetn(presetn),
        .slow(slow), .regulator_ctrl_input_one(regulator_ctrl_input_one),
        .regulator_ctrl_input_two(regulator_ctrl_input_two),
        .regulator_ctrl_input_three(regulator_ctrl_input_three),
        .core_supply_ready_threshold(core_supply_ready_threshold),
        .cpu_supply_ready_threshold(cpu_supply_ready_threshold));

    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // count and report one comparison
    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            n_fail++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask

    // verdict, the single exit of the run
    task automatic wrap_up;
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer, answer noted for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        aq.push_back(e);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);  // a hang is the watchdog's
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);  // gap so the strobe is never driven twice at one edge
    endtask

    // wait for an observed output to reach a level, cycles counted
    task automatic wait_on(input int idx, input logic v, output int c);
        c = 0;
        while (obs[idx] !== v && c < 3000) begin @(posedge pclk); c++; end
        if (c >= 3000) chk(1'b0, "wait stuck");
    endtask

    // monitor: apb answers and every change of the regulator levels
    always @(posedge pclk) begin
        if (!presetn) begin
            prev = 3'h7;
        end else begin
            if (pready === 1'b1) begin
                if (aq.size() == 0) chk(1'b0, "answer without request");
                else chk(pslverr === aq[0][32] && (!aq[0][33] || prdata === aq[0][31:0]),
                         "apb answer");
                if (aq.size() != 0) void'(aq.pop_front());
            end
            chk(regulator_ctrl_input_three === regulator_ctrl_input_two, "reset follow");
            if (trip !== prev) begin
                if (sq.size() == 0) chk(1'b0, "extra level change");
                else chk(trip === sq[0], "request order");
                if (sq.size() != 0) void'(sq.pop_front());
                prev = trip;
            end
        end
    end

    // stimulus
    initial begin
        seed = 85; n_fail = 0; checked = 0; presetn = 1'b0; slow = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
        wake_pin = 1'b0; extended_interrupt_line_two = 1'b0; wake_other = 1'b0;
        cpus_off = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, SPS_D2HOLD_OFS, 32'h0000_0000, {2'b10, SPS_D2HOLD_RST});
        apb(1'b0, 12'h020, 32'h0000_0000, {2'b11, 32'h0000_0000});
        hold  = 32'(4 + ($random(seed) & 7));
        d2low = 32'(64 + ($random(seed) & 7));
        cpus_off <= 1'($random(seed));
        // min-low spans outlast the modelled rail fall, even when slow
        apb(1'b1, SPS_D1LOW_OFS, 32'h0000_0044, 34'h0_0000_0000);
        apb(1'b1, SPS_D2HOLD_OFS, hold, 34'h0_0000_0000);
        apb(1'b1, SPS_D2LOW_OFS, d2low, 34'h0_0000_0000);
        apb(1'b1, SPS_CSET_OFS, 32'h0000_0004, 34'h0_0000_0000);
        apb(1'b1, SPS_USET_OFS, 32'h0000_0004, 34'h0_0000_0000);
        apb(1'b1, SPS_RETX_OFS, 32'h0000_000C, 34'h0_0000_0000);
        apb(1'b0, SPS_D2LOW_OFS, 32'h0000_0000, {2'b10, d2low});
        // standby: cpu first, core after hold-off, core back first
        sq.push_back(3'h4); sq.push_back(3'h0); sq.push_back(3'h4); sq.push_back(3'h7);
        cpus_off <= 1'b1;
        apb(1'b1, SPS_CTRL_OFS, 32'h0000_0007, 34'h0_0000_0000);
        wait_on(4, 1'b0, n);
        wake_other <= 1'b1;  // early wake must be held, not dropped
        @(posedge pclk);
        chk(obs[5] === 1'b1 && cpu1_reset_n === 1'b0, "cpu first");
        wait_on(5, 1'b0, n);
        chk(n + 1 >= int'(hold) && n <= int'(hold) + 3, "hold-off span");
        wait_on(5, 1'b1, n);
        wake_other <= 1'b0;
        chk(n >= int'(d2low) && n <= int'(d2low) + 3 && obs[4] === 1'b0, "core min-low");
        wait_on(4, 1'b1, n);
        chk(n >= PDLY + 4 && obs[2] === 1'b1, "core settle");
        wait_on(0, 1'b1, n);
        chk(n >= PDLY + 4 && obs[1] === 1'b1, "cpu settle");
        // stop mode, woken by the pin, by line two, then by the other source
        for (k = 0; k < 3; k++) begin
            sq.push_back(3'h0);
            if (k == 2) sq.push_back(3'h4);
            sq.push_back(3'h7);
            apb(1'b1, SPS_CTRL_OFS, 32'h0000_000F, 34'h0_0000_0000);
            wait_on(5, 1'b0, n);
            if (k == 0) wake_pin <= 1'b1;
            else if (k == 1) extended_interrupt_line_two <= 1'b1;
            else wake_other <= 1'b1;
            wait_on(5, 1'b1, n);
            chk(obs[4] === (k < 2) && obs[3] === obs[4], "stop wake");
            wake_pin <= 1'b0; extended_interrupt_line_two <= 1'b0; wake_other <= 1'b0;
            slow <= 1'($random(seed));
            wait_on(0, 1'b1, n);
            chk(n >= PDLY + 12 && obs[1] === 1'b1, "stop settle");
        end
        repeat (5) @(posedge pclk);
        chk(sq.size() == 0 && aq.size() == 0, "missing results");
        wrap_up();
    end

    // watchdog, the whole run needs far fewer cycles than this
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
